// >>> rtl/crt_timing_pkg.sv
// Overview of operation
// R1 - Dot counter advances every dot clock edge
// R2 - Dot counter cycles nine states, reloads one
// R3 - Dot bit two qualifies line-buffer read clock
// R4 - Carry once per nine dots advances horizontal
// R5 - Horizontal counter is decade plus binary stage
// R6 - Horizontal counts only on character carry
// R7 - Refresh enable during first 80 characters
// R8 - Then 3 porch, 2 sync, 17 back porch
// R9 - Vertical counter increments per horizontal sync
// R10 - Vertical unblank during first 240 lines
// R11 - 60 Hz: 2 porch, 6 sync, 17 back
// R12 - 50 Hz: 28 porch, 6 sync, 44 back
// R13 - Request bus with hold, processor acknowledges
// R14 - When granted, drive address and read strobe
// R15 - Memory returns code and asserts ready
// R16 - Codes go to basic or extended buffer
// R17 - Read flag sets on phase four when granted
// R18 - Hold clears after read; acknowledge drop clears
// R19 - Active-low ready enables line-buffer write clock
// R20 - Reset clears counters and request flags; dot counter loads one
package crt_timing_pkg;
  localparam logic [3:0] DOT_FIRST    = 4'h1;
  localparam logic [3:0] DOT_LAST     = 4'h9;
  localparam int         DOT_READ_BIT = 2;
  localparam int         H_VISIBLE    = 80;
  localparam int         H_FPORCH     = 3;
  localparam int         H_SYNC       = 2;
  localparam int         H_BPORCH     = 17;
  localparam int         V_VISIBLE    = 240;
  localparam int         V_ROW_LINES  = 10;
  localparam int         V_BASIC_ROWS = 12;
  localparam int         V60_FPORCH   = 2;
  localparam int         V60_SYNC     = 6;
  localparam int         V60_BPORCH   = 17;
  localparam int         V50_FPORCH   = 28;
  localparam int         V50_SYNC     = 6;
  localparam int         V50_BPORCH   = 44;
  localparam int         CODE_W       = 8;
  localparam int         ADDR_W       = 16;
  localparam int         FIFO_DEPTH   = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              mem_read;
    logic              addr_en;
  } bus_drive_t;

  typedef struct packed {
    logic              ext_buf;
    logic [CODE_W-1:0] code;
  } fetch_word_t;
endpackage

// >>> rtl/code_fifo.sv
`timescale 1ns/1ns
module code_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = (AW+1)'(cnt_reg + push - pop);
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule // code_fifo

// >>> rtl/crt_refresh_timing.sv
`timescale 1ns/1ns
module crt_refresh_timing
  import crt_timing_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              mode_50hz,
  input  wire logic              refresh_req,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  input  wire logic              phase4_n,
  input  wire logic              bus_grant_ack,
  input  wire logic              ready_n,
  input  wire logic [CODE_W-1:0] data_in,
  output logic                   hold_req,
  output bus_drive_t             bus_out,
  output logic                   read_clk_en,
  output logic                   char_carry,
  output logic                   h_refresh_en,
  output logic                   h_sync,
  output logic                   v_unblank,
  output logic                   v_sync,
  output logic                   buf_valid,
  input  wire logic              buf_ready,
  output fetch_word_t            buf_word
);
  localparam int H_TOTAL = H_VISIBLE + H_FPORCH + H_SYNC + H_BPORCH;

  // Pin synchronisers; first stage feeds only the second
  logic p4_s1, p4_s2, p4_s3, ack_s1, ack_s2, rdy_s1, rdy_s2;
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      p4_s1  <= 1'b1;
      p4_s2  <= 1'b1;
      p4_s3  <= 1'b1;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
    end
    else
    begin
      p4_s1  <= phase4_n;
      p4_s2  <= p4_s1;
      p4_s3  <= p4_s2;
      ack_s1 <= bus_grant_ack;
      ack_s2 <= ack_s1;
      rdy_s1 <= ready_n;
      rdy_s2 <= rdy_s1;
    end
  end
  logic p4_rise;
  assign p4_rise = p4_s2 && !p4_s3;

  // Dot counter
  logic [3:0] dot_reg, dot_next;
  always_comb
  begin
    dot_next = (dot_reg == DOT_LAST) ? DOT_FIRST : 4'(dot_reg + 4'h1); // [R1] [R2]
  end
  assign char_carry  = (dot_reg == DOT_LAST);                            // [R4]
  assign read_clk_en = dot_reg[DOT_READ_BIT];                            // [R3]

  // Horizontal: decade stage plus binary group stage
  logic [3:0] hdec_reg, hdec_next;
  logic [3:0] hgrp_reg, hgrp_next;
  logic [6:0] hpos;
  assign hpos = 7'(hgrp_reg * 10 + hdec_reg);                             // [R5]
  always_comb
  begin
    hdec_next = hdec_reg;
    hgrp_next = hgrp_reg;
    if (char_carry)                                                       // [R6]
    begin
      if (hpos == 7'(H_TOTAL - 1))
      begin
        hdec_next = 4'h0;
        hgrp_next = 4'h0;
      end
      else if (hdec_reg == 4'h9)
      begin
        hdec_next = 4'h0;
        hgrp_next = 4'(hgrp_reg + 4'h1);                                  // [R5]
      end
      else
        hdec_next = 4'(hdec_reg + 4'h1);
    end
  end
  assign h_refresh_en = (hpos < 7'(H_VISIBLE));                            // [R7]
  assign h_sync = (hpos >= 7'(H_VISIBLE + H_FPORCH))
               && (hpos < 7'(H_VISIBLE + H_FPORCH + H_SYNC));              // [R8]
  logic h_bporch;
  assign h_bporch = (hpos >= 7'(H_VISIBLE + H_FPORCH + H_SYNC));

  // Vertical: increments on the start of each sync pulse
  logic h_sync_d_reg;
  logic line_step;
  assign line_step = h_sync && !h_sync_d_reg;                              // [R9]
  logic [8:0] vline_reg, vline_next;
  logic [8:0] v_fp, v_sy, v_bp, v_total;
  always_comb
  begin
    v_fp = mode_50hz ? 9'(V50_FPORCH) : 9'(V60_FPORCH);                    // [R11] [R12]
    v_sy = mode_50hz ? 9'(V50_SYNC) : 9'(V60_SYNC);
    v_bp = mode_50hz ? 9'(V50_BPORCH) : 9'(V60_BPORCH);
    v_total = 9'(V_VISIBLE) + v_fp + v_sy + v_bp;
    vline_next = vline_reg;
    if (line_step)
      vline_next = (vline_reg >= v_total - 9'h001) ? 9'h000 : 9'(vline_reg + 9'h001); // [R9]
  end
  assign v_unblank = (vline_reg < 9'(V_VISIBLE));                          // [R10]
  assign v_sync = (vline_reg >= 9'(V_VISIBLE) + v_fp)
               && (vline_reg < 9'(V_VISIBLE) + v_fp + v_sy);              // [R11] [R12]

  // Bus request and read flags; mode switch takes effect mid-frame, accepted
  logic hold_reg, hold_next, rd_reg, rd_next;
  logic fifo_in_ready;
  always_comb
  begin
    hold_next = hold_reg;
    rd_next   = rd_reg;
    if (refresh_req && h_bporch && fifo_in_ready && !rd_reg)
      hold_next = 1'b1;                                                   // [R13]
    else if (rd_reg && !(refresh_req && h_bporch))
      hold_next = 1'b0;                                                   // [R18]
    if (!ack_s2)
      rd_next = 1'b0;                                                     // [R18]
    else if (p4_rise && hold_reg)
      rd_next = 1'b1;                                                     // [R17]
  end
  assign hold_req = hold_reg;                                             // [R13]

  // Ready low with read active writes one code; ready is a memory promise
  logic rdy_seen_reg, rdy_seen_next;
  logic wr_pulse;
  assign wr_pulse = rd_reg && !rdy_s2 && !rdy_seen_reg;                   // [R19] [R15]
  always_comb
  begin
    rdy_seen_next = rd_reg ? (rdy_seen_reg || !rdy_s2) : 1'b0;
  end

  bus_drive_t  bus_reg, bus_next;
  fetch_word_t word_reg, word_next;
  always_comb
  begin
    bus_next.addr_en  = hold_reg && ack_s2;                               // [R14]
    bus_next.mem_read = rd_reg;                                           // [R14]
    bus_next.addr     = bus_next.addr_en ? fetch_addr : '0;
    word_next.code    = data_in;
    word_next.ext_buf = (vline_reg >= 9'(V_ROW_LINES * V_BASIC_ROWS));    // [R16]
  end
  assign bus_out = bus_reg;

  logic word_valid_reg, word_valid_next;
  always_comb
  begin
    word_valid_next = wr_pulse;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)                                                            // [R20]
    begin
      dot_reg        <= DOT_FIRST;
      hdec_reg       <= 4'h0;
      hgrp_reg       <= 4'h0;
      vline_reg      <= 9'h000;
      h_sync_d_reg   <= 1'b0;
      hold_reg       <= 1'b0;
      rd_reg         <= 1'b0;
      rdy_seen_reg   <= 1'b0;
      bus_reg        <= '0;
      word_reg       <= '0;
      word_valid_reg <= 1'b0;
    end
    else
    begin
      dot_reg        <= dot_next;
      hdec_reg       <= hdec_next;
      hgrp_reg       <= hgrp_next;
      vline_reg      <= vline_next;
      h_sync_d_reg   <= h_sync;
      hold_reg       <= hold_next;
      rd_reg         <= rd_next;
      rdy_seen_reg   <= rdy_seen_next;
      bus_reg        <= bus_next;
      word_valid_reg <= word_valid_next;
      if (wr_pulse)
        word_reg     <= word_next;                                       // [R16]
    end
  end

  // Hold is only raised while the buffer has room, so no code is dropped
  code_fifo #(
    .WIDTH ($bits(fetch_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (word_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (word_reg),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_word)
  );
endmodule // crt_refresh_timing

// >>> test/crt_refresh_timing_asserts.sv
`timescale 1ns/1ns
module crt_checks
  import crt_timing_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       refresh_req,
  input wire logic       bus_grant_ack,
  input wire logic       ready_n,
  input wire logic       hold_req,
  input wire bus_drive_t bus_out,
  input wire logic       read_clk_en,
  input wire logic       char_carry,
  input wire logic       h_refresh_en,
  input wire logic       h_sync,
  input wire logic       buf_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_CARRY: assert property (char_carry |=> !char_carry [*8] ##1 char_carry)
    else $error("carry spacing");
  AST_RDCLK: assert property (char_carry |=> !read_clk_en [*3] ##1 read_clk_en [*4]
    ##1 !read_clk_en [*2]) else $error("read clock window");
  AST_BPORCH: assert property ($fell(h_sync) |-> ##152 !h_refresh_en ##1 h_refresh_en)
    else $error("back porch length");
  AST_HOLD: assert property ($rose(hold_req) |-> $past(refresh_req) && !$past(h_refresh_en))
    else $error("hold outside porch");
  // Grant passes two sync stages, so allow a small window
  AST_GRANT: assert property ($rose(bus_grant_ack) && hold_req
    |-> ##[1:5] bus_out.addr_en) else $error("address not driven");
  AST_RDGNT: assert property ($rose(bus_out.mem_read) |-> hold_req && bus_out.addr_en)
    else $error("read without grant");
  AST_WRITE: assert property ($fell(ready_n) && bus_out.mem_read |-> ##[2:8] buf_valid)
    else $error("code not buffered");
  AST_RESET: assert property ($rose(rstn) |-> !hold_req && !buf_valid && h_refresh_en)
    else $error("reset state");
  cover property ($rose(bus_out.mem_read));
  cover property (buf_valid ##1 !buf_valid);
  cover property ($fell(h_sync) ##1 hold_req);
endmodule // crt_checks
bind crt_refresh_timing crt_checks i_chk (.*);

// >>> test/bus_partner.sv
`timescale 1ns/1ns
module bus_partner
  import crt_timing_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [2:0]        lag,
  input  wire logic              hold_req,
  input  wire bus_drive_t        bus_out,
  output logic                   bus_grant_ack,
  output logic                   phase4_n,
  output logic                   ready_n,
  output logic      [CODE_W-1:0] data_in
);
  logic [2:0] wait_cnt;
  logic [2:0] ph_cnt;
  logic       pend;
  initial
  begin
    {bus_grant_ack, wait_cnt, ph_cnt, data_in} = '0;
    phase4_n = 1'b1;
    ready_n  = 1'b1;
  end
  assign pend = (hold_req != bus_grant_ack) || (bus_out.mem_read == ready_n);
  always @(posedge mclk)
  begin
    ph_cnt   <= ph_cnt + 3'h1;
    phase4_n <= ph_cnt[2];
    wait_cnt <= pend ? wait_cnt + 3'h1 : 3'h0;
    // Slow answers are modelled by lag cycles of delay
    if (pend && wait_cnt >= lag)
    begin
      bus_grant_ack <= hold_req;
      ready_n       <= !bus_out.mem_read;
    end
    // Idle bus toggles between the last code and its inverse each cycle
    data_in <= bus_out.mem_read ? bus_out.addr[7:0] ^ 8'h5a : ~data_in;
  end
endmodule // bus_partner

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import crt_timing_pkg::*;
  localparam int LINE_CYC = (H_VISIBLE + H_FPORCH + H_SYNC + H_BPORCH) * 9;
  logic              mclk, rstn, mode_50hz, refresh_req, buf_ready, phase4_n;
  logic              bus_grant_ack, ready_n, hold_req, read_clk_en, char_carry;
  logic              h_refresh_en, h_sync, v_unblank, v_sync, buf_valid, prev_hold;
  logic [ADDR_W-1:0] fetch_addr;
  logic [CODE_W-1:0] data_in;
  logic [2:0]        lag;
  logic [31:0]       seed;
  bus_drive_t        bus_out;
  fetch_word_t       buf_word;
  fetch_word_t       exp_q[$];
  int                n_mismatch, n_tests, n_vis, n_car, n_syn, n_hold, cnt;

  crt_refresh_timing i_dut (.*);
  bus_partner i_far (.*);

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Run stays in the top half of the screen, so only the basic buffer is used
  function automatic fetch_word_t code_of(input logic [ADDR_W-1:0] a);
    return {1'b0, a[CODE_W-1:0] ^ 8'h5a};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic step;
    @(posedge mclk);
    #10;
  endtask
  task automatic to_porch;
    cnt = 0;
    while (h_sync !== 1'b1 && cnt < 2000)
    begin
      step;
      cnt++;
    end
    while (h_sync === 1'b1 && cnt < 2000)
    begin
      step;
      cnt++;
    end
    if (cnt >= 2000)
    begin
      n_mismatch++;
      wrap_up;
    end
  endtask
  task automatic line_window;
    {n_vis, n_car, n_syn, n_hold} = '0;
    prev_hold = 1'b0;
    repeat (LINE_CYC)
    begin
      n_vis += (h_refresh_en === 1'b1);
      n_car += (char_carry === 1'b1);
      n_syn += (h_sync === 1'b1);
      n_hold += (hold_req === 1'b1 && !prev_hold);
      prev_hold = hold_req;
      step;
    end
  endtask
  initial
  begin
    seed = 32'h773bb6f9;
    {n_mismatch, n_tests} = '0;
    rstn = 1'b0;
    mode_50hz = seed[3];
    refresh_req = 1'b0;
    buf_ready = 1'b0;
    fetch_addr = '0;
    lag = '0;
    repeat (12) @(posedge mclk);
    #10;
    rstn = 1'b1;
    check({h_refresh_en, v_unblank, hold_req, buf_valid}, 32'hc);
    // Windows then run back to back from porch start, so no porch goes uncounted
    to_porch;
    // Sink stalls: sixteen fetches fill the buffer, the next is refused
    for (int i = 0; i < FIFO_DEPTH + 2; i++)
    begin
      seed = xs(seed);
      fetch_addr = seed[ADDR_W-1:0];
      lag = seed[18:16];
      refresh_req = (i != 0);
      line_window;
      check(n_hold, i > 0 && i <= FIFO_DEPTH);
      if (n_hold == 1)
        exp_q.push_back(code_of(fetch_addr));
    end
    check(n_vis, H_VISIBLE * 9);
    check(n_car, LINE_CYC / 9);
    check(n_syn, H_SYNC * 9);
    refresh_req = 1'b0;
    cnt = 0;
    while (exp_q.size() > 0 && cnt < 5000)
    begin
      @(negedge mclk);
      if (buf_valid === 1'b1 && buf_ready === 1'b1)
        check(buf_word, exp_q.pop_front());
      step;
      seed = xs(seed);
      buf_ready = seed[0];
      cnt++;
    end
    if (cnt >= 5000)
      n_mismatch++;
    step;
    check(buf_valid, 32'h0);
    check(v_unblank, 32'h1);
    // A whole frame is beyond the run budget, so only the top lines are seen
    check(v_sync, 32'h0);
    wrap_up;
  end
endmodule // tb_top
